// ---- sph_pkg.sv ----
// sph_pkg: constants and types for the strobed port handshake block
package sph_pkg;

    // ****************************************************************
    // register map, byte addresses on the wishbone bus
    // ****************************************************************
    localparam logic [7:0] SPH_OFS_PORT_A    = 8'h00; // first port byte
    localparam logic [7:0] SPH_OFS_PORT_B    = 8'h04; // second port byte
    localparam logic [7:0] SPH_OFS_DIR_A     = 8'h08; // first_port_direction
    localparam logic [7:0] SPH_OFS_DIR_B     = 8'h0c; // second_port_direction
    localparam logic [7:0] SPH_OFS_MODE      = 8'h10; // port_mode_reg
    localparam logic [7:0] SPH_OFS_STATUS    = 8'h14; // handshake status
    localparam logic       SPH_BITOP_TAG     = 1'b1;  // adr[7] of bit ops

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SPH_MODE_M_POS   = 5;  // strobed mode select
    localparam int SPH_MODE_OUT_POS = 6;  // output direction
    localparam int SPH_MODE_TS_POS  = 7;  // float bus until acknowledge
    localparam int SPH_BIT_PORT_POS = 3;  // bit op index: port select
    localparam int SPH_BIT_SET_POS  = 4;  // bit op index: set when one
    localparam int SPH_FLAG_BIT     = 6;  // second_port_bit_six
    localparam int SPH_IE_BIT       = 7;  // second_port_bit_seven
    localparam int SPH_MSB_BIT      = 7;  // data_bus_msb

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] SPH_RST_BYTE = 8'h00;
    localparam logic       SPH_RST_BIT  = 1'b0;

    // ****************************************************************
    // first port modes, gray coded
    // ****************************************************************
    typedef enum logic [1:0] {
        SPH_BASIC  = 2'b00,
        SPH_S_IN   = 2'b01,
        SPH_S_OUT  = 2'b11,
        SPH_S_TRI  = 2'b10
    } sph_mode_t;

endpackage : sph_pkg

// ---- sph_sync_edge.sv ----
// sph_sync_edge: two-stage synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module sph_sync_edge (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic async_in,
    output logic      level,
    output logic      fell,
    output logic      rose
);
    logic meta;
    logic level_q;

    // two flops; only the second one is examined
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta  <= 1'b1;
            level <= 1'b1;
        end else begin
            meta  <= async_in;
            level <= meta;
        end
    end

    // delayed copy of the clean level; the first flop is never looked at
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_q <= 1'b1;
        end else begin
            level_q <= level;
        end
    end

    // one-cycle pulses on falling and rising edges of the clean level
    assign fell = level_q & ~level;
    assign rose = ~level_q & level;
endmodule // sph_sync_edge
`default_nettype wire

// ---- sph_port_top.sv ----
// sph_port_top: first-port strobed handshake with wishbone register slave
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sph_port_top
    import sph_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [7:0]       pa_in,
    output logic      [7:0]       pa_out,
    output logic      [7:0]       pa_oe,
    input  wire logic [7:0]       pb_in,
    output logic      [7:0]       pb_out,
    output logic      [7:0]       pb_oe,
    output logic                  irq_request_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] pa_lat;       // first port output latch
    logic [7:0] pa_inlat;     // first port strobed input latch
    logic [7:0] pb_lat;       // second port output latch, bit6 flag bit7 ie
    logic [7:0] dir_a;        // first_port_direction
    logic [7:0] dir_b;        // second_port_direction
    logic [7:0] port_mode_reg;
    logic       irq_req;      // interrupt request latch
    logic       stb_level;
    logic       stb_fell;
    logic       stb_rose;
    sph_mode_t  mode;

    // ****************************************************************
    // strobe / acknowledge synchroniser on second-port bit 7
    // ****************************************************************
    sph_sync_edge u_stb (
        .clock    (clock),
        .resetn   (resetn),
        .async_in (pb_in[SPH_IE_BIT]),
        .level    (stb_level),
        .fell     (stb_fell),
        .rose     (stb_rose)
    );

    // ****************************************************************
    // mode decode
    // ****************************************************************
    always_comb begin
        if (!port_mode_reg[SPH_MODE_M_POS]) begin
            mode = SPH_BASIC;
        end else if (!port_mode_reg[SPH_MODE_OUT_POS]) begin
            mode = SPH_S_IN;
        end else if (port_mode_reg[SPH_MODE_TS_POS]) begin
            mode = SPH_S_TRI;
        end else begin
            mode = SPH_S_OUT;
        end
    end

    logic strobed;
    logic out_mode;
    assign strobed  = (mode != SPH_BASIC);
    assign out_mode = (mode == SPH_S_OUT) || (mode == SPH_S_TRI);

    // ****************************************************************
    // bus decode; an access takes effect at the edge ack is seen high
    // ****************************************************************
    logic       req;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       is_bitop;
    logic [2:0] bit_idx;
    logic       bit_port_b;
    logic       bit_set;
    logic       lane0;

    assign req        = wb_cyc_i & wb_stb_i;
    assign acc        = req & wb_ack_o;
    assign lane0      = wb_sel_i[0];
    assign wr         = acc & wb_we_i;
    assign rd         = acc & ~wb_we_i;
    assign is_bitop   = (wb_adr_i[7] == SPH_BITOP_TAG); // clears reachable
    assign bit_idx    = wb_adr_i[4:2];
    assign bit_port_b = wb_adr_i[2+SPH_BIT_PORT_POS];
    assign bit_set    = wb_adr_i[2+SPH_BIT_SET_POS];

    logic wr_a_byte;
    logic rd_a_byte;
    logic wr_b_byte;
    logic mode_wr;
    logic bit_wr_b;
    assign wr_a_byte = wr & lane0 & (wb_adr_i == SPH_OFS_PORT_A);
    assign wr_b_byte = wr & lane0 & (wb_adr_i == SPH_OFS_PORT_B);
    assign rd_a_byte = rd & (wb_adr_i == SPH_OFS_PORT_A);
    assign mode_wr   = wr & lane0 & (wb_adr_i == SPH_OFS_MODE);
    assign bit_wr_b  = wr & is_bitop & bit_port_b;

    // ack one cycle after request, dropped the cycle after
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // ****************************************************************
    // read data mux
    // ****************************************************************
    logic [7:0] a_view;
    logic [7:0] b_view;
    logic [7:0] rd_byte;
    logic       sel_bit;

    always_comb begin
        a_view = (dir_a & pa_lat) | (~dir_a & pa_in);
        if (mode == SPH_S_IN) begin
            a_view = pa_inlat;
        end
        b_view  = (dir_b & pb_lat) | (~dir_b & pb_in);
        sel_bit = bit_port_b ? b_view[bit_idx] : a_view[bit_idx];
        if (bit_port_b && bit_idx == 3'(SPH_IE_BIT) && strobed) begin
            sel_bit = irq_req;
        end
        rd_byte = SPH_RST_BYTE;
        if (is_bitop) begin
            rd_byte[SPH_MSB_BIT] = sel_bit;
        end else begin
            case (wb_adr_i)
                SPH_OFS_PORT_A: rd_byte = a_view;
                SPH_OFS_PORT_B: rd_byte = b_view;
                SPH_OFS_DIR_A:  rd_byte = dir_a;
                SPH_OFS_DIR_B:  rd_byte = dir_b;
                SPH_OFS_MODE:   rd_byte = port_mode_reg;
                SPH_OFS_STATUS: rd_byte = {6'h00, irq_req, stb_level};
                default:        rd_byte = SPH_RST_BYTE;
            endcase
        end
    end

    // read data captured as ack rises, zero otherwise
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end else begin
            wb_dat_o <= 32'h00000000;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dir_a         <= SPH_RST_BYTE;
            dir_b         <= SPH_RST_BYTE;
            port_mode_reg <= SPH_RST_BYTE;
        end else if (wr && lane0) begin
            if (wb_adr_i == SPH_OFS_DIR_A) begin
                dir_a <= wb_dat_i[7:0];
            end
            if (wb_adr_i == SPH_OFS_DIR_B) begin
                dir_b <= wb_dat_i[7:0];
            end
            if (wb_adr_i == SPH_OFS_MODE) begin
                port_mode_reg <= wb_dat_i[7:0];
            end
        end
    end

    // ****************************************************************
    // first port latches
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pa_lat <= SPH_RST_BYTE;
        end else if (wr_a_byte) begin
            pa_lat <= wb_dat_i[7:0];
        end else if (wr && is_bitop && !bit_port_b) begin
            pa_lat[bit_idx] <= bit_set;
        end
    end

    // strobe trailing edge loads pins, later strobes overwrite
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pa_inlat <= SPH_RST_BYTE;
        end else if (mode == SPH_S_IN && stb_rose) begin
            pa_inlat <= pa_in;
        end
    end

    // ****************************************************************
    // second port latch with handshake flag (bit 6) and enable (bit 7)
    // ****************************************************************
    logic [7:0] next_pb_lat;
    logic [7:0] keep_mask;

    always_comb begin
        next_pb_lat = pb_lat;
        keep_mask   = strobed ? 8'hc0 : 8'h00;
        if (wr_b_byte) begin
            // masked handshake bits survive byte writes
            next_pb_lat = (wb_dat_i[7:0] & ~keep_mask)
                        | (pb_lat & keep_mask);
        end
        if (bit_wr_b) begin
            next_pb_lat[bit_idx] = bit_set;
        end
        if (mode_wr) begin
            if (wb_dat_i[SPH_MODE_M_POS] && !wb_dat_i[SPH_MODE_OUT_POS]) begin
                next_pb_lat[SPH_FLAG_BIT] = 1'b0;
            end
            if (wb_dat_i[SPH_MODE_M_POS] && wb_dat_i[SPH_MODE_OUT_POS]) begin
                next_pb_lat[SPH_FLAG_BIT] = 1'b1;
            end
        end
        if (mode == SPH_S_IN) begin
            if (rd_a_byte) begin
                next_pb_lat[SPH_FLAG_BIT] = 1'b0;
            end
            if (stb_fell) begin
                next_pb_lat[SPH_FLAG_BIT] = 1'b1;
            end
        end
        if (out_mode) begin
            if (wr_a_byte) begin
                next_pb_lat[SPH_FLAG_BIT] = 1'b0;
            end
            if (stb_fell) begin
                next_pb_lat[SPH_FLAG_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pb_lat <= SPH_RST_BYTE;
        end else begin
            pb_lat <= next_pb_lat;
        end
    end

    // ****************************************************************
    // interrupt request latch; hardware set wins over clear
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_req <= SPH_RST_BIT;
        end else if (mode == SPH_S_IN && stb_rose) begin
            irq_req <= 1'b1;
        end else if (out_mode && stb_rose) begin
            irq_req <= 1'b1;
        end else if (mode_wr && wb_dat_i[SPH_MODE_M_POS]) begin
            // output modes start requesting only when enabled
            irq_req <= wb_dat_i[SPH_MODE_OUT_POS]
                     & pb_lat[SPH_IE_BIT];
        end else if (mode == SPH_S_IN && rd_a_byte) begin
            irq_req <= 1'b0;
        end else if (out_mode && wr_a_byte) begin
            irq_req <= 1'b0;
        end else if (!strobed) begin
            irq_req <= 1'b0;
        end
    end

    // ****************************************************************
    // registered pin and interrupt outputs
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pa_out          <= SPH_RST_BYTE;
            pa_oe           <= SPH_RST_BYTE;
            pb_out          <= SPH_RST_BYTE;
            pb_oe           <= SPH_RST_BYTE;
            irq_request_out <= SPH_RST_BIT;
        end else begin
            pa_out <= pa_lat;
            if (mode == SPH_S_TRI) begin
                pa_oe <= stb_level ? 8'h00 : dir_a;
            end else begin
                pa_oe <= dir_a;
            end
            pb_out          <= pb_lat;
            pb_oe           <= dir_b;
            irq_request_out <= pb_lat[SPH_IE_BIT] & irq_req;
        end
    end

endmodule // sph_port_top
`default_nettype wire

// ---- sph_port_props.sv ----
// sph_port_props: concurrent checks on the strobed port block ports
`timescale 1ns/1ps
`default_nettype none
module sph_port_props
    import sph_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input wire logic             clock,
    input wire logic             resetn,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic [7:0]       pa_in,
    input wire logic [7:0]       pa_out,
    input wire logic [7:0]       pa_oe,
    input wire logic [7:0]       pb_in,
    input wire logic [7:0]       pb_out,
    input wire logic [7:0]       pb_oe,
    input wire logic             irq_request_out
);
    // ****************************************************************
    // mode shadow and strobe-high counter
    // ****************************************************************
    logic [7:0] mode_q;
    logic [2:0] hi_cnt;
    logic       ack_rd, ack_wr, m_in, m_out, m_tri;
    // decoded access and mode flags
    assign ack_rd = wb_ack_o & wb_cyc_i & wb_stb_i & ~wb_we_i;
    assign ack_wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign m_in   = mode_q[6:5] == 2'b01;
    assign m_out  = mode_q[6:5] == 2'b11;
    assign m_tri  = mode_q[7:5] == 3'b111;
    // copy of the mode register taken at the write's ack edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) mode_q <= SPH_RST_BYTE;
        else if (ack_wr && wb_adr_i[7:0] == SPH_OFS_MODE) mode_q <= wb_dat_i[7:0];
    end
    // cycles the strobe pin has stayed high, saturating at 7
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) hi_cnt <= 3'h0;
        else if (!pb_in[7]) hi_cnt <= 3'h0;
        else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_irq_gated: assert property (
        (!pb_out[7]) [*3] |-> !irq_request_out) else $error("irq without enable");
    a_irq_basic: assert property (
        (!mode_q[5]) [*4] |-> !irq_request_out) else $error("irq in basic mode");
    a_flag_fall: assert property (
        (m_in || m_out) && $fell(pb_in[7]) |-> ##[2:6] pb_out[6])
        else $error("flag not set on strobe fall");
    a_irq_rise: assert property (
        (m_in || m_out) && pb_out[7] && $rose(pb_in[7])
        |-> ##[2:7] irq_request_out) else $error("irq not set on strobe rise");
    a_rd_clears: assert property (
        m_in && ack_rd && wb_adr_i[7:0] == SPH_OFS_PORT_A
        |-> ##[1:3] (!pb_out[6] && !irq_request_out))
        else $error("port read left status set");
    a_wr_clears: assert property (
        m_out && ack_wr && wb_adr_i[7:0] == SPH_OFS_PORT_A
        |-> ##[1:3] (!pb_out[6] && !irq_request_out))
        else $error("port write left status set");
    a_bit_read: assert property (
        ack_rd && wb_adr_i[7] == SPH_BITOP_TAG
        |-> wb_dat_o[31:8] == 24'h000000 && wb_dat_o[6:0] == 7'h00)
        else $error("bit read has stray bits");
    a_pb_keep: assert property (
        mode_q[5] && ack_wr && wb_adr_i[7:0] == SPH_OFS_PORT_B
        |-> ##2 pb_out[7:6] == $past(pb_out[7:6]))
        else $error("handshake bits hit");
    a_tri_float: assert property (
        m_tri && $past(m_tri) && hi_cnt == 3'h7 |-> pa_oe == 8'h00)
        else $error("port driven without acknowledge");
    c_strobe_in: cover property (m_in && $fell(pb_in[7]));
    c_tri_drive: cover property (m_tri && pa_oe != 8'h00);
    c_bit_read: cover property (ack_rd && wb_adr_i[7] == SPH_BITOP_TAG);
endmodule // sph_port_props
bind sph_port_top sph_port_props #(.ADR_W(ADR_W)) props_u (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .irq_request_out(irq_request_out)
);
`default_nettype wire

// ---- sph_periph_model.sv ----
// sph_periph_model: peripheral that strobes data in or acknowledges data
`timescale 1ns/1ps
`default_nettype none
module sph_periph_model (
    input  wire logic       clock,
    input  wire logic [7:0] pa_out,
    output logic            strb_n,
    output logic [7:0]      bus,
    output logic [7:0]      seen
);
    // idle: strobe high, released bus shows a non-data pattern
    initial begin
        strb_n = 1'b1;
        bus    = 8'hff;
        seen   = 8'h00;
    end
    // one pulse low for lo cycles; data held past the trailing edge
    task automatic pulse(input logic [7:0] d, input int lo);
        @(posedge clock);
        bus    <= d;
        strb_n <= 1'b0;
        repeat (lo) @(posedge clock);
        strb_n <= 1'b1;
        seen   <= pa_out;
        repeat (6) @(posedge clock);
        bus    <= ~d;
    endtask
endmodule // sph_periph_model
`default_nettype wire

// ---- sph_port_top_tb_top.sv ----
// sph_port_top_tb_top: register-level tests of the strobed port block
`timescale 1ns/1ps
`default_nettype none
module sph_port_top_tb_top import sph_pkg::*;;
    // ****************************************************************
    // signals, models and bus tasks
    // ****************************************************************
    logic        clock, resetn, cyc, stb, we, ack, irq, strb_n;
    logic [7:0]  adr, q, pa_out, pa_oe, pb_out, pb_oe, bus, seen, pa_w;
    logic [31:0] dat, rdat;
    logic [3:0]  sel;
    logic [5:0]  pb_low;
    int          n_errors, num_checks;
    // pin level: the port drives where enabled, the peripheral elsewhere
    assign pa_w = (pa_oe & pa_out) | (~pa_oe & bus);
    always #20 clock = ~clock;
    sph_port_top #(.ADR_W(8)) dut_u (
        .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pa_in(pa_w), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_in({strb_n, 1'b0, pb_low}), .pb_out(pb_out),
        .pb_oe(pb_oe), .irq_request_out(irq));
    sph_periph_model periph_u (
        .clock(clock), .pa_out(pa_w), .strb_n(strb_n), .bus(bus),
        .seen(seen));
    // verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // compare one result byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic wishbone cycle, ack awaited under a bound
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_errors++;
            $display("FAIL %0t no ack", $time);
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // handshake view: enable, flag, request
    function automatic logic [7:0] hs();
        return {pb_out[7:6], 5'h00, irq};
    endfunction
    // ****************************************************************
    // main sequence: strobed input, output, float output, no enable
    // ****************************************************************
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        dat = 32'h00000000;
        sel = 4'h1;
        pb_low = 6'h15;
        n_errors = 0;
        num_checks = 0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        rd(SPH_OFS_MODE, 8'h00);
        rd(8'h3c, 8'h00);
        xfer(1'b1, SPH_OFS_DIR_B, 8'h40);
        xfer(1'b1, 8'hfc, 8'h00);
        xfer(1'b1, SPH_OFS_MODE, 8'h20);
        idle(3);
        chk(hs(), 8'h80);
        periph_u.pulse(8'ha5, 8);
        idle(2);
        chk(hs(), 8'hc1);
        periph_u.pulse(8'h3c, 3);
        idle(2);
        rd(SPH_OFS_PORT_B, 8'hd5);
        xfer(1'b1, SPH_OFS_PORT_A, 8'h11);
        xfer(1'b1, SPH_OFS_PORT_B, 8'h00);
        rd(8'hfc, 8'h80);
        idle(2);
        chk(hs(), 8'hc1);
        rd(SPH_OFS_PORT_A, 8'h3c);
        idle(3);
        chk(hs(), 8'h80);
        xfer(1'b1, SPH_OFS_DIR_A, 8'hff);
        xfer(1'b1, SPH_OFS_MODE, 8'h60);
        idle(3);
        chk(hs(), 8'hc1);
        chk(pa_oe, 8'hff);
        xfer(1'b1, SPH_OFS_PORT_A, 8'h5a);
        idle(3);
        chk(hs(), 8'h80);
        rd(SPH_OFS_PORT_A, 8'h5a);
        xfer(1'b1, 8'hc0, 8'h00);
        idle(2);
        chk(hs(), 8'h80);
        periph_u.pulse(8'h00, 8);
        idle(2);
        chk(hs(), 8'hc1);
        chk(seen, 8'h5b);
        xfer(1'b1, SPH_OFS_PORT_A, 8'h77);
        xfer(1'b1, 8'hf8, 8'h00);
        idle(3);
        chk(hs(), 8'hc0);
        xfer(1'b1, 8'hb8, 8'h00);
        idle(3);
        chk(hs(), 8'h80);
        xfer(1'b1, SPH_OFS_MODE, 8'he0);
        idle(3);
        chk(pa_oe, 8'h00);
        xfer(1'b1, SPH_OFS_PORT_A, 8'h96);
        fork
            periph_u.pulse(8'h00, 10);
            begin
                idle(7);
                chk(pa_oe, 8'hff);
            end
        join
        idle(2);
        chk(pa_oe, 8'h00);
        chk(hs(), 8'hc1);
        chk(seen, 8'h96);
        xfer(1'b1, SPH_OFS_MODE, 8'h00);
        xfer(1'b1, SPH_OFS_PORT_B, 8'h00);
        xfer(1'b1, SPH_OFS_MODE, 8'h60);
        idle(3);
        chk(hs(), 8'h40);
        periph_u.pulse(8'h00, 8);
        idle(2);
        chk(hs(), 8'h40);
        close_out();
    end
endmodule // sph_port_top_tb_top
`default_nettype wire
